//--- fall_through_cfg.svh
// Timing, width and reset constants for the fall-through depth chain.
// Assumes one 25 MHz clock shared by writer, reader and every stage.
`ifndef FALL_THROUGH_CFG_SVH
`define FALL_THROUGH_CFG_SVH

// ****************************************
// Widths and depths
// ****************************************
`define FT_DATA_WIDTH      9
`define FT_STAGE_DEPTH     8
`define FT_CHAIN_STAGES    2

// ****************************************
// Clock
// ****************************************
`define FT_CLK_PERIOD_NS   40

// ****************************************
// Flag latencies in clock cycles
// ****************************************
`define FT_OR_STAGE_CYCLES 3
`define FT_OR_HOP_CYCLES   4
`define FT_IR_STAGE_CYCLES 2
`define FT_IR_HOP_CYCLES   3

// ****************************************
// Mode strap capture
// ****************************************
`define FT_STRAP_CNT_W     2
`define FT_STRAP_SETTLE    2'h3
`define FT_STRAP_CNT_ZERO  2'h0
`define FT_STRAP_CNT_ONE   2'h1

`endif

//--- fall_through_pkg.sv
// Types shared by the fall-through depth chain.
// Assumes the constants header is on the include path.
`include "fall_through_cfg.svh"

package fall_through_pkg;

	// ****************************************
	// Types
	// ****************************************
	typedef logic [`FT_DATA_WIDTH-1:0] word_t;

	typedef enum logic
	{
		strap_wait,
		strap_held
	} strap_e;

endpackage

//--- fall_through_stage_fifo.sv
// Storage of one chain stage: a show-ahead FIFO with valid and ready on both sides.
// Assumes the caller never pushes while in_ready_out is low.
`timescale 1ns/100ps

module fall_through_stage_fifo #(
	parameter int WIDTH = 9,
	parameter int DEPTH = 8,
	parameter int CW    = $clog2(DEPTH + 1)
)
(
	// Clock and reset
	input  wire logic             ref_clk_in,
	input  wire logic             reset_in,
	// Fill side
	input  wire logic             in_valid_in,
	output logic                  in_ready_out,
	input  wire logic [WIDTH-1:0] in_data_in,
	// Drain side
	output logic                  out_valid_out,
	input  wire logic             out_ready_in,
	output logic [WIDTH-1:0]      out_data_out,
	// Fill level
	output logic [CW-1:0]         count_out
);

	localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0]    wr_ptr;
	logic [AW-1:0]    rd_ptr;
	logic [CW-1:0]    count;

	wire              push;
	wire              pop;
	wire [AW-1:0]     next_wr_ptr;
	wire [AW-1:0]     next_rd_ptr;

	// ****************************************
	// Handshake decode
	// ****************************************
	assign in_ready_out  = (count != CW'(DEPTH));
	assign out_valid_out = (count != '0);
	assign push          = in_valid_in & in_ready_out;
	assign pop           = out_ready_in & out_valid_out;
	assign out_data_out  = mem[rd_ptr];
	assign count_out     = count;
	assign next_wr_ptr   = (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + AW'(1);
	assign next_rd_ptr   = (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + AW'(1);

	// ****************************************
	// Pointers and level
	// ****************************************
	always_ff @(posedge ref_clk_in or posedge reset_in)
	begin
		if (reset_in)
		begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count  <= '0;
		end
		else
		begin
			if (push)
				wr_ptr <= next_wr_ptr;
			if (pop)
				rd_ptr <= next_rd_ptr;
			count <= count + CW'(push) - CW'(pop);
		end
	end

	// Array has no reset so it maps onto plain RAM
	always_ff @(posedge ref_clk_in)
	begin
		if (push)
			mem[wr_ptr] <= in_data_in;
	end

endmodule

//--- fall_through_depth_chain.sv
// Depth-expansion chain of fall-through FIFO stages joined output to input.
// Assumes writer and reader run on ref_clk_in; the mode strap may come from a pin.
`timescale 1ns/100ps
`include "fall_through_cfg.svh"

// Operation
// - Stages in series act as one FIFO holding the sum of stage depths plus one output word per stage.
// - Word at a stage output drops its output-ready, enabling the next stage write.
// - Empty chain: last output-ready low after (N-1)*4 transfer plus 3 read clocks.
// - Ripple delay hits only the first word; later words add no chain delay.
// - Freed slot drops that stage's input-ready so the preceding stage refills it.
// - Full chain: first input-ready low after (N-1)*3 transfer plus 2 write clocks.
module fall_through_depth_chain #(
	parameter int WIDTH  = `FT_DATA_WIDTH,
	parameter int DEPTH  = `FT_STAGE_DEPTH,
	parameter int STAGES = `FT_CHAIN_STAGES
)
(
	// Clock and reset
	input  wire logic              ref_clk_in,
	input  wire logic              reset_in,
	// Mode strap
	input  wire logic              fall_through_mode_in,
	// Write side of the first stage
	input  wire logic              write_en_n_in,
	input  wire logic [WIDTH-1:0]  data_in,
	output logic                   input_ready_n_out,
	// Read side of the last stage
	input  wire logic              read_en_n_in,
	output logic [WIDTH-1:0]       data_out,
	output logic                   output_ready_n_out,
	// Per-stage flags
	output logic [STAGES-1:0]      stage_output_ready_n_out,
	output logic [STAGES-1:0]      stage_input_ready_n_out
);

	localparam int CW     = $clog2(DEPTH + 1);
	localparam int TW     = $clog2(STAGES * (DEPTH + 1) + 1);
	localparam int LAST   = STAGES - 1;
	localparam int RIPPLE = (STAGES - 1) * `FT_OR_HOP_CYCLES + `FT_OR_STAGE_CYCLES;
	localparam int BUBBLE = (STAGES - 1) * `FT_IR_HOP_CYCLES + `FT_IR_STAGE_CYCLES;
	localparam int RIPPLE_PRE = RIPPLE - 1;
	localparam int BUBBLE_PRE = BUBBLE - 1;
	localparam int RIPPLE_SEEN = RIPPLE + 1;
	localparam logic [TW-1:0] CAPACITY = TW'(STAGES * (DEPTH + 1));

	// ****************************************
	// Mode strap capture
	// ****************************************
	logic                       mode_s1;
	logic                       mode_s2;
	logic                       mode_s3;
	logic [`FT_STRAP_CNT_W-1:0] strap_cnt;
	fall_through_pkg::strap_e   strap_state;
	logic                       chain_run;

	wire                        strap_stable;

	assign strap_stable = (mode_s2 == mode_s3);

	always_ff @(posedge ref_clk_in or posedge reset_in)
	begin
		if (reset_in)
		begin
			mode_s1 <= 1'b0;
			mode_s2 <= 1'b0;
			mode_s3 <= 1'b0;
		end
		else
		begin
			mode_s1 <= fall_through_mode_in;
			mode_s2 <= mode_s1;
			mode_s3 <= mode_s2;
		end
	end

	// Strap is caught once after release; later changes are ignored until the next reset
	always_ff @(posedge ref_clk_in or posedge reset_in)
	begin
		if (reset_in)
		begin
			strap_state <= fall_through_pkg::strap_wait;
			strap_cnt   <= `FT_STRAP_CNT_ZERO;
			chain_run   <= 1'b0;
		end
		else
		begin
			case (strap_state)
				fall_through_pkg::strap_wait:
				begin
					if (strap_cnt != `FT_STRAP_SETTLE)
						strap_cnt <= strap_cnt + `FT_STRAP_CNT_ONE;
					else if (strap_stable)
					begin
						chain_run   <= mode_s3;
						strap_state <= fall_through_pkg::strap_held;
					end
				end
				fall_through_pkg::strap_held:
				begin
					chain_run <= chain_run;
				end
				default:
				begin
					strap_state <= fall_through_pkg::strap_wait;
				end
			endcase
		end
	end

	// ****************************************
	// Stage state
	// ****************************************
	logic [WIDTH-1:0]           stage_word [STAGES];
	logic [STAGES-1:0]          word_ready_n;
	logic [STAGES-1:0]          ir_n;
	logic [STAGES-1:0]          head_a;
	logic [STAGES-1:0]          head_b;
	logic [STAGES-1:0]          space_a;
	logic [STAGES-1:0]          space_b;

	wire  [STAGES-1:0]          push;
	wire  [STAGES-1:0]          drain;
	wire  [STAGES-1:0]          load;
	wire  [STAGES-1:0]          fifo_valid;
	wire  [STAGES-1:0]          fifo_ready;
	wire  [STAGES-1:0]          will_full;
	wire  [WIDTH-1:0]           feed [STAGES];
	wire  [WIDTH-1:0]           fifo_head [STAGES];
	wire  [CW-1:0]              fifo_count [STAGES];
	wire  [CW-1:0]              count_after [STAGES];

	genvar i;
	generate
		for (i = 0; i < STAGES; i++)
		begin : g_stage
			// Write into a stage needs its own input-ready low
			if (i == 0)
			begin : g_head
				assign push[i] = chain_run & ~write_en_n_in & ~ir_n[i];
				assign feed[i] = data_in;
			end
			else
			begin : g_link
				assign push[i] = ~word_ready_n[i-1] & ~ir_n[i];
				assign feed[i] = stage_word[i-1];
			end

			if (i == LAST)
			begin : g_tail
				assign drain[i] = ~read_en_n_in & ~word_ready_n[i];
			end
			else
			begin : g_mid
				assign drain[i] = push[i+1];
			end

			// Two-cycle head settle gives the three-cycle fall-through per stage
			assign load[i]        = fifo_valid[i] & head_b[i] & (word_ready_n[i] | drain[i]);
			assign count_after[i] = fifo_count[i] + CW'(push[i]) - CW'(load[i]);
			assign will_full[i]   = (count_after[i] == CW'(DEPTH));

			fall_through_stage_fifo #(
				.WIDTH (WIDTH),
				.DEPTH (DEPTH),
				.CW    (CW)
			) u_store (
				.ref_clk_in    (ref_clk_in),
				.reset_in      (reset_in),
				.in_valid_in   (push[i]),
				.in_ready_out  (fifo_ready[i]),
				.in_data_in    (feed[i]),
				.out_valid_out (fifo_valid[i]),
				.out_ready_in  (load[i]),
				.out_data_out  (fifo_head[i]),
				.count_out     (fifo_count[i])
			);

			property p_store_room;
				@(posedge ref_clk_in) disable iff (reset_in)
				push[i] |-> fifo_ready[i];
			endproperty
			a_store_room: assert property (p_store_room) else $error("write into a full stage store");

			always_ff @(posedge ref_clk_in or posedge reset_in)
			begin
				if (reset_in)
				begin
					stage_word[i]   <= '0;
					word_ready_n[i] <= 1'b1;
					head_a[i]       <= 1'b0;
					head_b[i]       <= 1'b0;
				end
				else
				begin
					head_a[i] <= fifo_valid[i];
					head_b[i] <= head_a[i] & fifo_valid[i];
					if (load[i])
					begin
						stage_word[i]   <= fifo_head[i];
						word_ready_n[i] <= 1'b0;
					end
					else if (drain[i])
						word_ready_n[i] <= 1'b1;
				end
			end

			// Flag rises in the same edge that fills the last slot, so no write is lost
			always_ff @(posedge ref_clk_in or posedge reset_in)
			begin
				if (reset_in)
				begin
					space_a[i] <= 1'b0;
					space_b[i] <= 1'b0;
					ir_n[i]    <= 1'b1;
				end
				else
				begin
					space_a[i] <= ~will_full[i];
					space_b[i] <= space_a[i] & ~will_full[i];
					ir_n[i]    <= ~(chain_run & space_b[i] & ~will_full[i]);
				end
			end
		end
	endgenerate

	// ****************************************
	// Outputs
	// ****************************************
	assign data_out                 = stage_word[LAST];
	assign output_ready_n_out       = word_ready_n[LAST];
	assign input_ready_n_out        = ir_n[0];
	assign stage_output_ready_n_out = word_ready_n;
	assign stage_input_ready_n_out  = ir_n;

	// ****************************************
	// Checks
	// ****************************************
	logic [TW-1:0] chain_level;

	always_comb
	begin
		chain_level = '0;
		for (int k = 0; k < STAGES; k++)
			chain_level = chain_level + TW'(fifo_count[k]) + TW'(word_ready_n[k] == 1'b0);
	end

	wire chain_empty;
	wire chain_full;

	assign chain_empty = (chain_level == '0);
	assign chain_full  = (chain_level == CAPACITY);

	property p_ripple_first;
		@(posedge ref_clk_in) disable iff (reset_in)
		(push[0] & chain_empty) |=> ##RIPPLE !output_ready_n_out;
	endproperty
	a_ripple_first: assert property (p_ripple_first) else $error("first word late at chain output");

	property p_ripple_not_early;
		@(posedge ref_clk_in) disable iff (reset_in)
		(push[0] & chain_empty) |=> ##RIPPLE_PRE output_ready_n_out;
	endproperty
	a_ripple_not_early: assert property (p_ripple_not_early) else $error("first word early at chain output");

	property p_bubble_first;
		@(posedge ref_clk_in) disable iff (reset_in)
		(chain_full & drain[LAST]) |=> ##BUBBLE !input_ready_n_out;
	endproperty
	a_bubble_first: assert property (p_bubble_first) else $error("free slot late at chain input");

	property p_bubble_not_early;
		@(posedge ref_clk_in) disable iff (reset_in)
		(chain_full & drain[LAST]) |=> ##BUBBLE_PRE input_ready_n_out;
	endproperty
	a_bubble_not_early: assert property (p_bubble_not_early) else $error("free slot early at chain input");

	property p_stage_fall;
		@(posedge ref_clk_in) disable iff (reset_in)
		(push[LAST] & (fifo_count[LAST] == '0) & word_ready_n[LAST] & read_en_n_in) |=> ##3 !word_ready_n[LAST];
	endproperty
	a_stage_fall: assert property (p_stage_fall) else $error("stage output not ready three cycles after write");

	property p_stream_no_gap;
		@(posedge ref_clk_in) disable iff (reset_in)
		(drain[LAST] & head_b[LAST] & (fifo_count[LAST] > CW'(1))) |=> !output_ready_n_out;
	endproperty
	a_stream_no_gap: assert property (p_stream_no_gap) else $error("gap between streamed words");

	property p_no_overflow;
		@(posedge ref_clk_in) disable iff (reset_in)
		(chain_level <= CAPACITY) and (chain_full |-> input_ready_n_out);
	endproperty
	a_no_overflow: assert property (p_no_overflow) else $error("chain level beyond its capacity");

	property p_free_slot;
		@(posedge ref_clk_in) disable iff (reset_in)
		(chain_run & will_full[0]) ##1 (!will_full[0]) [*3] |=> !input_ready_n_out;
	endproperty
	a_free_slot: assert property (p_free_slot) else $error("freed slot did not lower input ready");

	property p_order_pass;
		@(posedge ref_clk_in) disable iff (reset_in)
		(!word_ready_n[LAST] & !drain[LAST]) |=> (!output_ready_n_out & $stable(data_out));
	endproperty
	a_order_pass: assert property (p_order_pass) else $error("held output word changed before it was read");

	c_first_word: cover property (@(posedge ref_clk_in) disable iff (reset_in)
		push[0] & chain_empty ##RIPPLE_SEEN !output_ready_n_out);
	c_full_read:  cover property (@(posedge ref_clk_in) disable iff (reset_in) chain_full & drain[LAST]);
	c_stream:     cover property (@(posedge ref_clk_in) disable iff (reset_in) drain[LAST] ##1 drain[LAST] ##1 drain[LAST]);

endmodule

//--- chain_reader_model.sv
// Downstream reader model facing the last stage of the depth chain.
// Assumes want_in comes from the bench and the chain clock runs free.
`timescale 1ns/100ps

module chain_reader_model
(
	// Clock and reset
	input  wire logic ref_clk_in,
	input  wire logic reset_in,
	// Bench control
	input  wire logic want_in,
	// Chain read side
	input  wire logic output_ready_n_in,
	output logic      read_en_n_out
);
	logic want_q;

	always_ff @(posedge ref_clk_in or posedge reset_in)
	begin
		if (reset_in)
			want_q <= 1'b0;
		else
			want_q <= want_in;
	end

	// Falling-edge drive keeps the enable stable across the sampling edge
	always @(negedge ref_clk_in or posedge reset_in)
	begin
		if (reset_in)
			read_en_n_out <= 1'b1;
		else
			read_en_n_out <= ~(want_q & ~output_ready_n_in);
	end
endmodule

//--- fall_through_depth_chain_test.sv
// Self-checking bench for the fall-through depth chain.
// Assumes the constants header is on the include path.
`timescale 1ns/100ps
`include "fall_through_cfg.svh"

`define CHK(nm, exp, got) begin checks++; if ((got) !== (exp)) begin n_errors++; \
	$display("wrong value %s expected %h seen %h", nm, exp, got); end end

module fall_through_depth_chain_test;
	localparam int W      = `FT_DATA_WIDTH;
	localparam int N      = `FT_CHAIN_STAGES;
	localparam int CAP    = N * (`FT_STAGE_DEPTH + 1);
	localparam int OR_LAT = (N - 1) * `FT_OR_HOP_CYCLES + `FT_OR_STAGE_CYCLES;
	localparam int IR_LAT = (N - 1) * `FT_IR_HOP_CYCLES + `FT_IR_STAGE_CYCLES;

	logic                    ref_clk_in;
	logic                    reset_in;
	logic                    fall_through_mode_in;
	logic                    write_en_n_in;
	fall_through_pkg::word_t data_in;
	logic                    input_ready_n_out;
	logic                    read_en_n_in;
	fall_through_pkg::word_t data_out;
	logic                    output_ready_n_out;
	logic [N-1:0]            stage_output_ready_n_out;
	logic [N-1:0]            stage_input_ready_n_out;
	logic                    want;
	logic                    seen;
	fall_through_pkg::word_t exp_w;
	fall_through_pkg::word_t exp_q[$];
	int                      n_errors;
	int                      checks;
	int                      takes;
	int                      k;
	int                      n;
	int                      t0;
	int                      seed = 32'h1de8_5f25;

	fall_through_depth_chain #(.WIDTH(W), .DEPTH(`FT_STAGE_DEPTH), .STAGES(N)) i_fall_through_depth_chain
	(
		.ref_clk_in               (ref_clk_in),
		.reset_in                 (reset_in),
		.fall_through_mode_in     (fall_through_mode_in),
		.write_en_n_in            (write_en_n_in),
		.data_in                  (data_in),
		.input_ready_n_out        (input_ready_n_out),
		.read_en_n_in             (read_en_n_in),
		.data_out                 (data_out),
		.output_ready_n_out       (output_ready_n_out),
		.stage_output_ready_n_out (stage_output_ready_n_out),
		.stage_input_ready_n_out  (stage_input_ready_n_out)
	);

	chain_reader_model i_chain_reader_model
	(
		.ref_clk_in        (ref_clk_in),
		.reset_in          (reset_in),
		.want_in           (want),
		.output_ready_n_in (output_ready_n_out),
		.read_en_n_out     (read_en_n_in)
	);

	// ****************************************
	// Clock and monitor
	// ****************************************
	initial
	begin
		ref_clk_in = 1'b0;
		forever #20 ref_clk_in = ~ref_clk_in;
	end

	always @(posedge ref_clk_in)
	begin
		if (!reset_in && read_en_n_in === 1'b0 && output_ready_n_out === 1'b0)
		begin
			takes++;
			exp_w = (exp_q.size() != 0) ? exp_q.pop_front() : ~data_out;
			`CHK("data_out", exp_w, data_out)
		end
	end

	// ****************************************
	// Tasks
	// ****************************************
	task automatic final_report;
		$display("checks %0d mismatches %0d", checks, n_errors);
		if (n_errors == 0 && checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	task automatic timeout(input string nm);
		n_errors++;
		$display("wait for %s ran out", nm);
		final_report();
	endtask

	task automatic do_reset(input logic strap);
		reset_in = 1'b1;
		fall_through_mode_in = strap;
		write_en_n_in = 1'b1;
		want = 1'b0;
		exp_q.delete();
		repeat (20) @(negedge ref_clk_in);
		`CHK("flags in reset", {(2*N+2){1'b1}}, {input_ready_n_out, output_ready_n_out,
			stage_output_ready_n_out, stage_input_ready_n_out})
		`CHK("data_out in reset", {W{1'b0}}, data_out)
		reset_in = 1'b0;
	endtask

	task automatic wait_in_ready;
		k = 0;
		while (input_ready_n_out !== 1'b0)
		begin
			@(negedge ref_clk_in);
			k++;
			if (k > 200)
				timeout("input ready");
		end
	endtask

	task automatic drain(input string nm);
		want = 1'b1;
		k = 0;
		while (exp_q.size() != 0 && k < 500)
		begin
			@(negedge ref_clk_in);
			k++;
		end
		want = 1'b0;
		if (k >= 500)
			timeout("drain");
		repeat (4) @(negedge ref_clk_in);
		`CHK("output_ready_n_out after drain", 1'b1, output_ready_n_out)
		$display("test %s done", nm);
	endtask

	// ****************************************
	// Scenarios
	// ****************************************
	initial
	begin
		n_errors = 0;
		checks = 0;
		takes = 0;
		data_in = '0;
		do_reset(1'b1);
		wait_in_ready();
		// First word ripples down with no reads
		write_en_n_in = 1'b0;
		data_in = 9'h1a5;
		exp_q.push_back(data_in);
		@(negedge ref_clk_in);
		write_en_n_in = 1'b1;
		k = 0;
		n = -1;
		while (output_ready_n_out !== 1'b0 && k < 50)
		begin
			if (n < 0 && stage_output_ready_n_out[0] === 1'b0)
				n = k;
			@(negedge ref_clk_in);
			k++;
		end
		`CHK("first word latency", OR_LAT, k)
		`CHK("stage output ready", `FT_OR_STAGE_CYCLES, n)
		drain("first word");
		// Burst: only the first word pays the ripple
		for (int i = 0; i < 4; i++)
		begin
			write_en_n_in = 1'b0;
			data_in = W'(9'h040 + i);
			exp_q.push_back(data_in);
			@(negedge ref_clk_in);
		end
		write_en_n_in = 1'b1;
		repeat (12) @(negedge ref_clk_in);
		t0 = takes;
		want = 1'b1;
		repeat (5) @(negedge ref_clk_in);
		`CHK("back to back reads", 4, takes - t0)
		drain("burst");
		// Fill to capacity, refused write, then one bubble
		n = 0;
		while (input_ready_n_out === 1'b0 && n < 40)
		begin
			write_en_n_in = 1'b0;
			data_in = W'(n * 37);
			exp_q.push_back(data_in);
			n++;
			@(negedge ref_clk_in);
		end
		data_in = 9'h1ff;
		repeat (10) @(negedge ref_clk_in);
		write_en_n_in = 1'b1;
		`CHK("capacity", CAP, n)
		`CHK("input_ready_n_out full", 1'b1, input_ready_n_out)
		t0 = takes;
		want = 1'b1;
		@(negedge ref_clk_in);
		want = 1'b0;
		k = 0;
		while (takes == t0 && k < 20)
		begin
			@(negedge ref_clk_in);
			k++;
		end
		if (k >= 20)
			timeout("bubble read");
		k = 0;
		seen = 1'b0;
		while (input_ready_n_out !== 1'b0 && k < 50)
		begin
			if (stage_input_ready_n_out[N-1] === 1'b0)
				seen = 1'b1;
			@(negedge ref_clk_in);
			k++;
		end
		`CHK("bubble latency", IR_LAT, k)
		`CHK("last stage input ready", 1'b1, seen)
		drain("full chain");
		// Random traffic with a stalling reader
		repeat (400)
		begin
			write_en_n_in = 1'($random(seed));
			data_in = W'($random(seed));
			if (write_en_n_in === 1'b0 && input_ready_n_out === 1'b0)
				exp_q.push_back(data_in);
			want = 1'($random(seed));
			@(negedge ref_clk_in);
		end
		write_en_n_in = 1'b1;
		drain("random");
		// Standard mode strap leaves the chain idle
		do_reset(1'b0);
		write_en_n_in = 1'b0;
		repeat (20) @(negedge ref_clk_in);
		write_en_n_in = 1'b1;
		`CHK("input ready with strap low", 1'b1, input_ready_n_out)
		`CHK("output ready with strap low", 1'b1, output_ready_n_out)
		do_reset(1'b1);
		wait_in_ready();
		$display("test strap done");
		final_report();
	end

	initial
	begin
		repeat (100000) @(posedge ref_clk_in);
		timeout("whole run");
	end
endmodule
